// File: inc/mmdio_regs.vh
`ifndef MMDIO_REGS_VH
`define MMDIO_REGS_VH

`define MMDIO_AW 17
`define MMDIO_DW 32

`define MMDIO_RGN_STAT_LO 17'h00200
`define MMDIO_RGN_STAT_HI 17'h003fc
`define MMDIO_RGN_MAC_LO 17'h00400
`define MMDIO_RGN_MAC_HI 17'h004fc
`define MMDIO_RGN_MDIO_LO 17'h00500
`define MMDIO_RGN_MDIO_HI 17'h005fc
`define MMDIO_RGN_INTC_LO 17'h00600
`define MMDIO_RGN_INTC_HI 17'h006fc
`define MMDIO_RGN_FILT_LO 17'h00700
`define MMDIO_RGN_FILT_HI 17'h007fc
`define MMDIO_RGN_RXPTP_LO 17'h10000
`define MMDIO_RGN_RXPTP_HI 17'h10ffc
`define MMDIO_RGN_TXPTP_LO 17'h11000
`define MMDIO_RGN_TXPTP_HI 17'h117fc
`define MMDIO_RGN_AVB_LO 17'h12000
`define MMDIO_RGN_AVB_HI 17'h127fc
`define MMDIO_RGN_RTC_LO 17'h12800
`define MMDIO_RGN_RTC_HI 17'h13ffc

`define MMDIO_ADDR_RX_CFG 17'h00404
`define MMDIO_ADDR_TX_CFG 17'h00408
`define MMDIO_ADDR_SETUP 17'h00500
`define MMDIO_ADDR_CTRL 17'h00504
`define MMDIO_ADDR_WDATA 17'h00508
`define MMDIO_ADDR_RDATA 17'h0050c

`define MMDIO_CFG_W 16
`define MMDIO_CFG_RST_BIT 31
`define MMDIO_CFG_RST 16'h0000

`define MMDIO_DIV_W 6
`define MMDIO_DIV_RST 6'h00
`define MMDIO_SETUP_EN_BIT 6

`define MMDIO_CTRL_KIND_HI 15
`define MMDIO_CTRL_KIND_LO 14
`define MMDIO_CTRL_INIT_BIT 11
`define MMDIO_CTRL_PHY_HI 28
`define MMDIO_CTRL_PHY_LO 24
`define MMDIO_CTRL_REG_HI 20
`define MMDIO_CTRL_REG_LO 16
`define MMDIO_READY_BIT 7
`define MMDIO_RD_READY_BIT 16

`define MMDIO_KIND_WRITE 2'h1
`define MMDIO_KIND_READ 2'h2
`define MMDIO_START_CODE 2'h1
`define MMDIO_TURN_WRITE 2'h2
`define MMDIO_PREAMBLE 32'hffffffff

`define MMDIO_FRAME_W 64
`define MMDIO_CNT_W 6
`define MMDIO_LAST_BIT 6'h3f
`define MMDIO_TURN_BIT 6'h2e
`define MMDIO_DATA_BIT 6'h30

`endif

// File: core/mmdio_top.v
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "mmdio_regs.vh"

// Overview of operation
// [R1] Accesses to reserved addresses answer with an error pulse, not silent success.
// [R2] Host addresses decode into functional regions; gaps between them are reserved.
// [R3] Config writes accepted anytime; applied to outputs only outside a frame.
// [R4] Soft reset bits in config writes act immediately, no gap wait.
// [R5] MDIO master exists only as part of this management port.
// [R6] Only this master starts transactions; addressed PHY must respond.
// [R7] Each transaction is one serial frame synchronous to MDC.
// [R8] Write frame uses kind 01 and sends 16 data bits.
// [R9] Read frame uses kind 10; PHY returns 16 bits, master captures them.
// [R10] Separate serial data input, output and output enable signals.
// [R11] Integrator gives each PHY sharing the bus a distinct non-zero address.
// [R12] MDC equals clock divided by twice one plus 6-bit divider.
// [R13] Software keeps MDC at or below 2.5 MHz.
// [R14] Divider resets to zero; zero divider blocks enabling the interface.
// [R15] Write: load write data, then control with initiate, kind 1, addresses.
// [R16] Initiate drops ready; ready stays low until the frame completes.
// [R17] Read: control with initiate and kind 2; data valid when ready rises.
// [R18] Ready flag visible in control and read-data registers.
// [R19] Completion of a pending transaction raises an interrupt request pulse.
// [R20] Frame: 32 ones, start 01, kind, phy, reg, turnaround, 16 data MSB first.
// [R21] Drive changes after falling MDC; read samples on rising; release in read.
module mmdio_top (
    input wire clk,
    input wire rst,
    input wire [`MMDIO_AW-1:0] addr,
    input wire [`MMDIO_DW-1:0] wdata,
    input wire wr,
    input wire rd,
    output reg [`MMDIO_DW-1:0] rdata_q,
    output reg rd_err_q,
    output reg wr_err_q,
    input wire frame_active,
    output reg [`MMDIO_CFG_W-1:0] rx_cfg_q,
    output reg [`MMDIO_CFG_W-1:0] tx_cfg_q,
    output reg rx_soft_rst_q,
    output reg tx_soft_rst_q,
    output reg mdc_q,
    input wire mdio_in,
    output reg mdio_out_q,
    output reg mdio_oe_q,
    output reg irq_q
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    reg [`MMDIO_CFG_W-1:0] rx_pend_q;
    reg [`MMDIO_CFG_W-1:0] tx_pend_q;
    reg [`MMDIO_DIV_W-1:0] div_q;
    reg en_q;
    reg [`MMDIO_DW-1:0] ctrl_q;
    reg [`MMDIO_CFG_W-1:0] wdat_q;
    reg [`MMDIO_CFG_W-1:0] rdat_q;
    reg ready_q;
    reg state_q;
    reg [`MMDIO_DIV_W-1:0] div_cnt_q;
    reg [`MMDIO_CNT_W-1:0] bit_cnt_q;
    reg [`MMDIO_FRAME_W-1:0] shift_q;
    reg [`MMDIO_CFG_W-1:0] cap_q;
    reg is_read_q;
    reg mdio_s1_q;
    reg mdio_s2_q;

    reg mapped;
    always @* begin
        mapped = 1'b0;
        if ((addr >= `MMDIO_RGN_STAT_LO && addr <= `MMDIO_RGN_STAT_HI) ||
            (addr >= `MMDIO_RGN_MAC_LO && addr <= `MMDIO_RGN_MAC_HI) ||
            (addr >= `MMDIO_RGN_MDIO_LO && addr <= `MMDIO_RGN_MDIO_HI) ||
            (addr >= `MMDIO_RGN_INTC_LO && addr <= `MMDIO_RGN_INTC_HI) ||
            (addr >= `MMDIO_RGN_FILT_LO && addr <= `MMDIO_RGN_FILT_HI) ||
            (addr >= `MMDIO_RGN_RXPTP_LO && addr <= `MMDIO_RGN_RXPTP_HI) ||
            (addr >= `MMDIO_RGN_TXPTP_LO && addr <= `MMDIO_RGN_TXPTP_HI) ||
            (addr >= `MMDIO_RGN_AVB_LO && addr <= `MMDIO_RGN_AVB_HI) ||
            (addr >= `MMDIO_RGN_RTC_LO && addr <= `MMDIO_RGN_RTC_HI)) begin
            mapped = 1'b1; // [R2]
        end
    end

    // Regions whose internals live elsewhere read as zero and accept writes
    wire mis_align = |addr[1:0];
    wire acc_ok = mapped && !mis_align;

    wire wr_setup = wr && acc_ok && addr == `MMDIO_ADDR_SETUP;
    wire wr_ctrl = wr && acc_ok && addr == `MMDIO_ADDR_CTRL;
    wire [1:0] req_kind = wdata[`MMDIO_CTRL_KIND_HI:`MMDIO_CTRL_KIND_LO];
    wire kind_ok = req_kind == `MMDIO_KIND_WRITE || req_kind == `MMDIO_KIND_READ;
    // A request while busy or disabled is dropped; software polls ready first
    wire start = wr_ctrl && wdata[`MMDIO_CTRL_INIT_BIT] && ready_q && en_q && kind_ok;

    // Divider terminal count; each one toggles MDC
    wire tick = en_q && div_cnt_q == div_q; // [R12]
    wire fall = tick && mdc_q;
    wire rise = tick && !mdc_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 32'h00000000;
            rd_err_q <= 1'b0;
            wr_err_q <= 1'b0;
        end else begin
            rd_err_q <= rd && !acc_ok; // [R1]
            wr_err_q <= wr && !acc_ok; // [R1]
            rdata_q <= 32'h00000000;
            if (rd && acc_ok) begin
                case (addr)
                    `MMDIO_ADDR_RX_CFG: rdata_q <= {16'h0000, rx_pend_q};
                    `MMDIO_ADDR_TX_CFG: rdata_q <= {16'h0000, tx_pend_q};
                    `MMDIO_ADDR_SETUP: rdata_q <= {25'h0000000, en_q, div_q};
                    `MMDIO_ADDR_CTRL: begin
                        rdata_q <= {ctrl_q[31:8], ready_q, ctrl_q[6:0]}; // [R18]
                    end
                    `MMDIO_ADDR_WDATA: rdata_q <= {16'h0000, wdat_q};
                    `MMDIO_ADDR_RDATA: rdata_q <= {15'h0000, ready_q, rdat_q}; // [R18]
                    default: rdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_pend_q <= `MMDIO_CFG_RST;
            tx_pend_q <= `MMDIO_CFG_RST;
            rx_cfg_q <= `MMDIO_CFG_RST;
            tx_cfg_q <= `MMDIO_CFG_RST;
            rx_soft_rst_q <= 1'b0;
            tx_soft_rst_q <= 1'b0;
            div_q <= `MMDIO_DIV_RST;
            en_q <= 1'b0;
            wdat_q <= 16'h0000;
            ctrl_q <= 32'h00000000;
        end else begin
            rx_soft_rst_q <= wr && acc_ok && addr == `MMDIO_ADDR_RX_CFG &&
                             wdata[`MMDIO_CFG_RST_BIT]; // [R4]
            tx_soft_rst_q <= wr && acc_ok && addr == `MMDIO_ADDR_TX_CFG &&
                             wdata[`MMDIO_CFG_RST_BIT]; // [R4]
            if (wr && acc_ok && addr == `MMDIO_ADDR_RX_CFG) begin
                rx_pend_q <= wdata[`MMDIO_CFG_W-1:0]; // [R3]
            end
            if (wr && acc_ok && addr == `MMDIO_ADDR_TX_CFG) begin
                tx_pend_q <= wdata[`MMDIO_CFG_W-1:0]; // [R3]
            end
            // Held settings move out only in the gap, so a frame never sees a change
            if (!frame_active) begin
                rx_cfg_q <= rx_pend_q; // [R3]
                tx_cfg_q <= tx_pend_q; // [R3]
            end
            if (wr_setup) begin
                div_q <= wdata[`MMDIO_DIV_W-1:0];
                en_q <= wdata[`MMDIO_SETUP_EN_BIT] &&
                        (wdata[`MMDIO_DIV_W-1:0] != `MMDIO_DIV_RST); // [R14]
            end
            if (wr && acc_ok && addr == `MMDIO_ADDR_WDATA) begin
                wdat_q <= wdata[`MMDIO_CFG_W-1:0]; // [R15]
            end
            if (wr_ctrl && ready_q) begin
                ctrl_q <= wdata;
            end
        end
    end

    // Two-stage synchroniser for the PHY data line
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mdio_s1_q <= 1'b0;
            mdio_s2_q <= 1'b0;
        end else begin
            mdio_s1_q <= mdio_in;
            mdio_s2_q <= mdio_s1_q;
        end
    end

    // Serial engine: part of this management port only [R5]
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            div_cnt_q <= 6'h00;
            mdc_q <= 1'b0;
            bit_cnt_q <= 6'h00;
            shift_q <= 64'h0000000000000000;
            cap_q <= 16'h0000;
            rdat_q <= 16'h0000;
            is_read_q <= 1'b0;
            mdio_out_q <= 1'b0;
            mdio_oe_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            irq_q <= 1'b0;
            // MDC stands low outside frames, so bit 0 always gets a full low half
            if (!en_q || state_q == ST_IDLE || tick) begin
                div_cnt_q <= 6'h00;
            end else begin
                div_cnt_q <= div_cnt_q + 6'h01;
            end
            if (!en_q || state_q == ST_IDLE) begin
                mdc_q <= 1'b0;
            end else if (tick) begin
                mdc_q <= !mdc_q; // [R12]
            end
            case (state_q)
                ST_IDLE: begin
                    mdio_oe_q <= 1'b0;
                    if (start) begin
                        // Only this end opens a frame [R6]
                        state_q <= ST_RUN;
                        ready_q <= 1'b0; // [R16]
                        bit_cnt_q <= 6'h00;
                        is_read_q <= req_kind == `MMDIO_KIND_READ; // [R9]
                        shift_q <= {`MMDIO_PREAMBLE, `MMDIO_START_CODE, req_kind,
                                    wdata[`MMDIO_CTRL_PHY_HI:`MMDIO_CTRL_PHY_LO],
                                    wdata[`MMDIO_CTRL_REG_HI:`MMDIO_CTRL_REG_LO],
                                    `MMDIO_TURN_WRITE, wdat_q}; // [R20] [R8] [R15]
                        mdio_out_q <= 1'b1;
                        mdio_oe_q <= 1'b1; // [R10]
                    end
                end
                ST_RUN: begin
                    if (rise && is_read_q && bit_cnt_q >= `MMDIO_DATA_BIT) begin
                        cap_q <= {cap_q[14:0], mdio_s2_q}; // [R21] [R9]
                    end
                    if (fall) begin
                        if (bit_cnt_q == `MMDIO_LAST_BIT) begin
                            state_q <= ST_IDLE;
                            ready_q <= 1'b1; // [R16] [R17]
                            irq_q <= 1'b1; // [R19]
                            mdio_oe_q <= 1'b0;
                            if (is_read_q) begin
                                rdat_q <= cap_q; // [R17]
                            end
                        end else begin
                            bit_cnt_q <= bit_cnt_q + 6'h01; // [R7]
                            shift_q <= {shift_q[62:0], 1'b0};
                            mdio_out_q <= shift_q[62]; // [R21] [R20]
                            // Read turnaround and data leave the line to the PHY
                            mdio_oe_q <= !(is_read_q &&
                                           bit_cnt_q + 6'h01 >= `MMDIO_TURN_BIT); // [R21]
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule

// File: testbench/mmdio_checker.sv
`timescale 1ns/1ps
`include "mmdio_regs.vh"
module mmdio_checker (
    input wire clk,
    input wire rst,
    input wire [`MMDIO_AW-1:0] addr,
    input wire [`MMDIO_DW-1:0] wdata,
    input wire wr,
    input wire rd,
    input wire rd_err_q,
    input wire wr_err_q,
    input wire frame_active,
    input wire [`MMDIO_CFG_W-1:0] rx_cfg_q,
    input wire tx_soft_rst_q,
    input wire mdc_q,
    input wire mdio_out_q,
    input wire mdio_oe_q,
    input wire irq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_rd_err_cause: assert property (rd_err_q |-> $past(rd)) else $error("stray read error");
    a_wr_err_cause: assert property (wr_err_q |-> $past(wr)) else $error("stray write error");
    a_region_ok: assert property ($past(rd || wr) && $past(addr) == `MMDIO_RGN_STAT_LO
        |-> !(rd_err_q || wr_err_q)) else $error("mapped region refused");
    a_cfg_hold: assert property ($past(frame_active) |-> $stable(rx_cfg_q))
        else $error("config changed in frame");
    a_srst_now: assert property (tx_soft_rst_q |-> $past(wr && addr == `MMDIO_ADDR_TX_CFG
        && wdata[`MMDIO_CFG_RST_BIT])) else $error("soft reset without cause");
    a_mdc_high: assert property ($rose(mdc_q) |=> mdc_q) else $error("mdc high too short");
    a_out_on_fall: assert property ($changed(mdio_out_q) && $past(mdio_oe_q) && mdio_oe_q
        |-> !mdc_q) else $error("data moved off falling mdc");
    a_pre_first: assert property ($rose(mdio_oe_q) |-> mdio_out_q) else $error("no preamble");
    a_irq_end: assert property (irq_q |-> !mdio_oe_q && !mdc_q ##1 !irq_q)
        else $error("bad completion pulse");
    a_release_fall: assert property ($fell(mdio_oe_q) |-> !mdc_q) else $error("early release");
    cover property (irq_q);
    cover property (rd_err_q);
    cover property (tx_soft_rst_q);
endmodule
bind mmdio_top mmdio_checker i_mmdio_checker (.clk, .rst, .addr, .wdata, .wr, .rd, .rd_err_q,
    .wr_err_q, .frame_active, .rx_cfg_q, .tx_soft_rst_q, .mdc_q, .mdio_out_q, .mdio_oe_q, .irq_q);

// File: testbench/mmdio_phy_model.sv
`timescale 1ns/1ps
// Address must be unique and non-zero on a shared bus
module mmdio_phy_model #(parameter [4:0] PHY_ADDR = 5'h03) (
    input wire mdc,
    input wire out,
    input wire oe,
    output reg drv_en,
    output reg drv,
    output reg [63:0] frame
);
    reg [15:0] mem [0:31];
    reg [6:0] cnt;
    reg rd_mode;
    initial begin
        cnt = 0;
        rd_mode = 0;
        drv_en = 0;
        drv = 0;
        frame = 0;
    end
    // Bits taken on rising mdc, answer changes just after it
    always @(posedge mdc) begin
        if (cnt != 0 || oe) begin
            if (oe) begin
                frame = {frame[62:0], out};
            end
            cnt = cnt + 1;
            if (cnt == 46) begin
                rd_mode = frame[11:10] == 2'b10 && frame[9:5] == PHY_ADDR;
            end
            if (rd_mode && cnt == 47) begin
                drv_en = 1;
                drv = 0;
            end
            if (rd_mode && cnt > 47 && cnt < 64) begin
                drv = mem[frame[4:0]][63 - cnt];
            end
            if (cnt == 64) begin
                if (!rd_mode && frame[29:28] == 2'b01 && frame[27:23] == PHY_ADDR) begin
                    mem[frame[22:18]] = frame[15:0];
                end
                cnt = 0;
                rd_mode = 0;
                drv_en = 0;
            end
        end
    end
endmodule

// File: testbench/mmdio_top_tb.sv
`timescale 1ns/1ps
`include "mmdio_regs.vh"
module mmdio_top_tb;
    reg clk = 0, rst = 1, wr = 0, rd = 0, frame_active = 0, err;
    reg [16:0] addr = 0;
    reg [31:0] wdata = 0, got;
    wire [31:0] rdata_q;
    wire [15:0] rx_cfg_q, tx_cfg_q;
    wire [63:0] frame;
    wire rd_err_q, wr_err_q, rx_soft_rst_q, tx_soft_rst_q, mdc_q, mdio_out_q, mdio_oe_q, irq_q;
    wire drv_en, drv;
    // Pulled up when nobody drives it
    wire line = mdio_oe_q ? mdio_out_q : (drv_en ? drv : 1'b1);
    integer bad_count = 0, total_checks = 0, irqs = 0, i, n;
    localparam [7*17-1:0] TA = {17'h0, 17'h800, 17'h11800, 17'h14000, 17'h502, 17'h200, 17'h12000};
    mmdio_top i_mmdio_top (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata_q, .rd_err_q, .wr_err_q,
        .frame_active, .rx_cfg_q, .tx_cfg_q, .rx_soft_rst_q, .tx_soft_rst_q, .mdc_q,
        .mdio_in(line), .mdio_out_q, .mdio_oe_q, .irq_q);
    mmdio_phy_model i_mmdio_phy_model (.mdc(mdc_q), .out(mdio_out_q), .oe(mdio_oe_q), .drv_en,
        .drv, .frame);
    always #2.5 clk = ~clk;
    always @(posedge clk) if (irq_q === 1'b1) irqs = irqs + 1;
    task chk(input [63:0] g, input [63:0] e);
        total_checks = total_checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task summarize;
        if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task acc(input w, input [16:0] a, input [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 0;
        rd <= 0;
        @(negedge clk);
        got = rdata_q;
        err = w ? wr_err_q : rd_err_q;
    endtask
    // Polls ready; the bound covers one frame at the chosen divider
    task wait_ready;
        acc(0, `MMDIO_ADDR_CTRL, 0);
        chk(got[7], 0);
        for (i = 0; i < 3000 && got[7] !== 1'b1; i = i + 1) acc(0, `MMDIO_ADDR_CTRL, 0);
        if (got[7] !== 1'b1) begin
            bad_count = bad_count + 1;
            summarize;
        end
    endtask
    task t_reset;
        acc(0, `MMDIO_ADDR_SETUP, 0);
        chk(got, 0);
        acc(0, `MMDIO_ADDR_CTRL, 0);
        chk(got[7], 1);
        acc(0, `MMDIO_ADDR_RDATA, 0);
        chk(got[16], 1);
    endtask
    task t_decode;
        for (n = 0; n < 7; n = n + 1) begin
            acc(n[0], TA[n*17 +: 17], 0);
            chk({err, got}, {n > 1, 32'h0});
        end
    endtask
    task t_div0;
        acc(1, `MMDIO_ADDR_SETUP, 32'h40);
        acc(0, `MMDIO_ADDR_SETUP, 0);
        chk(got[6], 0);
        acc(1, `MMDIO_ADDR_CTRL, 32'h03054800);
        acc(0, `MMDIO_ADDR_CTRL, 0);
        chk({got[7], mdc_q, mdio_oe_q}, 3'b100);
    endtask
    task t_cfg;
        @(posedge clk);
        frame_active <= 1;
        acc(1, `MMDIO_ADDR_RX_CFG, 32'h1234);
        chk(rx_soft_rst_q, 0);
        acc(1, `MMDIO_ADDR_TX_CFG, 32'h80000055);
        chk(tx_soft_rst_q, 1);
        repeat (4) @(posedge clk);
        frame_active <= 0;
        #1 chk({rx_cfg_q, tx_cfg_q}, 0);
        repeat (3) @(posedge clk);
        #1 chk({rx_cfg_q, tx_cfg_q}, 32'h12340055);
    endtask
    task t_write;
        acc(1, `MMDIO_ADDR_SETUP, 32'h67);
        acc(1, `MMDIO_ADDR_WDATA, 32'ha5c3);
        acc(1, `MMDIO_ADDR_CTRL, 32'h03054800);
        @(negedge mdc_q);
        for (n = 0; n < 100 && mdc_q !== 1'b1; n = n + 1) begin
            @(posedge clk);
            #1;
        end
        chk(n, 40);
        wait_ready;
        chk(frame, {32'hffffffff, 4'b0101, 5'd3, 5'd5, 2'b10, 16'ha5c3});
        chk(irqs, 1);
    endtask
    task t_read;
        acc(1, `MMDIO_ADDR_CTRL, 32'h03058800);
        wait_ready;
        acc(0, `MMDIO_ADDR_RDATA, 0);
        chk(got[16:0], 17'h1a5c3);
        chk(frame[45:0], {32'hffffffff, 4'b0110, 5'd3, 5'd5});
        acc(1, `MMDIO_ADDR_CTRL, 32'h04058800);
        wait_ready;
        acc(0, `MMDIO_ADDR_RDATA, 0);
        chk({got[15:0], irqs}, {16'hffff, 32'd3});
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 0;
        t_reset;
        t_decode;
        t_div0;
        t_cfg;
        t_write;
        t_read;
        summarize;
    end
endmodule
